/* File: hw/rsc_defs.svh */
`ifndef RSC_DEFS_SVH
`define RSC_DEFS_SVH
// ----------------------------------------
// Timebase
// ----------------------------------------
`define RSC_CLK_NS 5
`define RSC_TICK_NS 100000
`define RSC_TICK_CYC (`RSC_TICK_NS / `RSC_CLK_NS)
// ----------------------------------------
// Times in 0.1 ms ticks, then step and cycle numbers
// ----------------------------------------
`define RSC_ON_T 14'h01F4
`define RSC_OFF_T 14'h0028
`define RSC_OFF_EXT_T 14'h00C8
`define RSC_MRS_T 14'h00C8
`define RSC_MRS_MIN 14'h00C3
`define RSC_MRS_MAX 14'h00CD
`define RSC_HDX_LEN 14'h00A4
`define RSC_HDX_MIN 14'h00A3
`define RSC_HDX_MAX 14'h00A9
`define RSC_HDX_WIN_LO 14'h001E
`define RSC_HDX_START 14'h0023
`define RSC_FDX_START 14'h01EA
`define RSC_FDX_MIN_END 14'h0208
`define RSC_FDX_SKIP 14'h02BC
`define RSC_FDX_MAX 14'h03E8
`define RSC_INIT_TO 14'h2EE0
`define RSC_STEP_LAST 5'h13
`define RSC_LAST_CYC 4'hA
`define RSC_FIRST_CYC 4'h1
`endif

/* File: hw/rsc_pkg.sv */
package rsc_pkg;
  typedef enum logic [2:0] {ST_WATCH, ST_SEARCH, ST_ON, ST_OFF} rsc_state_t;
  typedef enum logic [2:0] {CLS_NONE, CLS_MRS, CLS_HDX, CLS_FDX, CLS_BAD} rsc_cls_t;
  typedef struct packed {
    logic operational;
    logic [3:0] cycle;
    rsc_cls_t last_cls;
  } rsc_stat_t;
endpackage : rsc_pkg

/* File: hw/rsc_sync_ctrl.sv */
`timescale 1ns/1ps
`include "rsc_defs.svh"
module rsc_sync_ctrl #(
  parameter int unsigned TICK_CYC = `RSC_TICK_CYC,
  parameter logic [13:0] INIT_TO = `RSC_INIT_TO
) (
  input wire logic sys_clk_i,
  input wire logic reset_i,
  input wire logic sync_i,
  output logic sync_o,
  output logic sync_oe_o,
  input wire logic hdx_detect_i,
  input wire logic fdx_detect_i,
  input wire logic fdx_done_i,
  output logic field_on_o,
  output rsc_pkg::rsc_stat_t stat_o
);
  // ----------------------------------------
  // Line sampling and timebase
  // ----------------------------------------
  logic [1:0] sync_q;
  logic line_q;
  logic [14:0] tk_q;
  logic [13:0] wid_q, wid_d;
  wire logic line = sync_q[1];
  wire logic rise = line & ~line_q;
  wire logic fall = ~line & line_q;
  wire logic tick = (tk_q == 15'(TICK_CYC - 1));

  // Two flops before any logic looks at the pin
  always_ff @(posedge sys_clk_i) begin
    if (reset_i) begin
      sync_q <= 2'h0;
      line_q <= 1'b0;
      tk_q <= 15'h0000;
    end else begin
      sync_q <= {sync_q[0], sync_i};
      line_q <= line;
      tk_q <= tick ? 15'h0000 : tk_q + 15'h0001;
    end
  end

  // Width of the current high pulse, saturating so overlong stays overlong
  always_comb begin
    wid_d = wid_q;
    if (rise) begin
      wid_d = 14'h0000;
    end else if (line && tick && wid_q != 14'h3FFF) begin
      wid_d = wid_q + 14'h0001;
    end
  end

  // ----------------------------------------
  // Pulse classification
  // ----------------------------------------
  wire logic is_mrs = wid_q >= `RSC_MRS_MIN && wid_q <= `RSC_MRS_MAX;
  wire logic is_hdx = wid_q >= `RSC_HDX_MIN && wid_q <= `RSC_HDX_MAX;
  wire logic is_fdx = !is_mrs && !is_hdx && wid_q != 14'h0000 && wid_q <= `RSC_FDX_MAX;
  wire rsc_pkg::rsc_cls_t cls = is_mrs ? rsc_pkg::CLS_MRS : is_hdx ? rsc_pkg::CLS_HDX :
                                is_fdx ? rsc_pkg::CLS_FDX : rsc_pkg::CLS_BAD;
  wire logic too_long = line && wid_q > `RSC_MRS_MAX;

  // ----------------------------------------
  // Cycle sequencer
  // ----------------------------------------
  rsc_pkg::rsc_state_t st_q, st_d;
  rsc_pkg::rsc_cls_t kind_q, kind_d, last_q;
  logic [13:0] t_q, t_d, dcnt_q, dcnt_d;
  logic [4:0] stp_q, stp_d;
  logic [3:0] cyc_q, cyc_d;
  logic long_q, long_d, drv_q, drv_d, done_q, done_d;
  wire logic last_cyc = (cyc_q == `RSC_LAST_CYC);
  wire logic step_ok = stp_q == 5'h00 && t_q >= `RSC_FDX_MIN_END && t_q != `RSC_FDX_SKIP;
  wire logic fdx_own = drv_q && kind_q == rsc_pkg::CLS_FDX;

  // This process computes the sequencer next values; the clocked bank below also selects last_q and field_on_o
  always_comb begin
    st_d = st_q;
    kind_d = kind_q;
    cyc_d = cyc_q;
    long_d = long_q;
    drv_d = drv_q;
    dcnt_d = dcnt_q;
    t_d = tick ? t_q + 14'h0001 : t_q;
    stp_d = !tick ? stp_q : (stp_q == `RSC_STEP_LAST) ? 5'h00 : stp_q + 5'h01;
    // Timed own pulses end on their own count
    if (drv_q && !fdx_own && tick) begin
      dcnt_d = dcnt_q - 14'h0001;
      if (dcnt_q == 14'h0001) begin
        drv_d = 1'b0;
      end
    end
    case (st_q)
      rsc_pkg::ST_WATCH: begin
        // Any high level is activity, also a pulse still standing on re-entry
        if (line) begin
          st_d = rsc_pkg::ST_SEARCH;
        end else if (tick && t_q >= INIT_TO - 14'h0001) begin
          st_d = rsc_pkg::ST_SEARCH;
          drv_d = 1'b1;
          kind_d = rsc_pkg::CLS_MRS;
          dcnt_d = `RSC_MRS_T;
        end
      end
      rsc_pkg::ST_SEARCH: begin
        // Only a bad end of our own sync pulse sends us back to watch; a valid sync pulse moves us to ON below, other pulses leave us here
        // Own drive has ended before the line falls, so key on what was sent
        if (kind_q == rsc_pkg::CLS_MRS && fall && !is_mrs) begin
          st_d = rsc_pkg::ST_WATCH;
          t_d = 14'h0000;
          kind_d = rsc_pkg::CLS_NONE;
        end
      end
      rsc_pkg::ST_ON: begin
        if (tick && t_q == `RSC_FDX_START - 14'h0001 && !last_cyc && fdx_detect_i &&
            !done_q && !drv_q) begin
          drv_d = 1'b1;
          kind_d = rsc_pkg::CLS_FDX;
        end
        // Release only on whole steps so the length never lands at 20 ms
        if (fdx_own && ((done_q && step_ok) || t_q >= `RSC_FDX_MAX)) begin
          drv_d = 1'b0;
        end
        if (last_cyc && t_q >= `RSC_ON_T) begin
          st_d = rsc_pkg::ST_OFF;
          long_d = 1'b1;
          t_d = 14'h0000;
          if (!line) begin
            drv_d = 1'b1;
            kind_d = rsc_pkg::CLS_MRS;
            dcnt_d = `RSC_MRS_T;
          end
        end else if ((t_q >= `RSC_ON_T && !line && !drv_q) || t_q >= `RSC_FDX_MAX) begin
          st_d = rsc_pkg::ST_OFF;
          long_d = 1'b0;
          t_d = 14'h0000;
          if (fdx_own) begin
            drv_d = 1'b0;
          end
        end
      end
      default: begin
        if (!last_cyc && tick && t_q == `RSC_HDX_START && hdx_detect_i && !drv_q && !line) begin
          drv_d = 1'b1;
          kind_d = rsc_pkg::CLS_HDX;
          dcnt_d = `RSC_HDX_LEN;
          long_d = 1'b1;
        end
        if (rise && t_q >= `RSC_HDX_WIN_LO && t_q <= `RSC_OFF_T) begin
          long_d = 1'b1;
        end
        if (last_cyc && rise) begin
          t_d = 14'h0000;
        end
        if (last_cyc && (too_long || (kind_q == rsc_pkg::CLS_MRS && fall && !is_mrs))) begin
          st_d = rsc_pkg::ST_WATCH;
          drv_d = 1'b0;
          t_d = 14'h0000;
          kind_d = rsc_pkg::CLS_NONE;
        end else if (t_q >= (long_q ? `RSC_OFF_EXT_T : `RSC_OFF_T) && !(last_cyc && line)) begin
          st_d = rsc_pkg::ST_ON;
          cyc_d = last_cyc ? `RSC_FIRST_CYC : cyc_q + 4'h1;
          t_d = 14'h0000;
          stp_d = 5'h00;
          long_d = 1'b0;
          kind_d = rsc_pkg::CLS_NONE;
        end
      end
    endcase
    // Late done still counts: set beats the clear on entering ON
    done_d = fdx_done_i | (done_q & !(st_d == rsc_pkg::ST_ON && st_q != rsc_pkg::ST_ON));
    // A valid sync pulse ending starts cycle one from any tracking state
    if (fall && is_mrs && st_q != rsc_pkg::ST_WATCH) begin
      st_d = rsc_pkg::ST_ON;
      cyc_d = `RSC_FIRST_CYC;
      t_d = 14'h0000;
      stp_d = 5'h00;
      long_d = 1'b0;
      done_d = fdx_done_i;
      kind_d = rsc_pkg::CLS_NONE;
      if (fdx_own) begin
        drv_d = 1'b0;
      end
    end
  end

  // State bank
  always_ff @(posedge sys_clk_i) begin
    if (reset_i) begin
      st_q <= rsc_pkg::ST_WATCH;
      kind_q <= rsc_pkg::CLS_NONE;
      last_q <= rsc_pkg::CLS_NONE;
      t_q <= 14'h0000;
      dcnt_q <= 14'h0000;
      wid_q <= 14'h0000;
      stp_q <= 5'h00;
      cyc_q <= `RSC_FIRST_CYC;
      long_q <= 1'b0;
      drv_q <= 1'b0;
      done_q <= 1'b0;
      field_on_o <= 1'b0;
    end else begin
      st_q <= st_d;
      kind_q <= kind_d;
      last_q <= fall ? cls : last_q;
      t_q <= t_d;
      dcnt_q <= dcnt_d;
      wid_q <= wid_d;
      stp_q <= stp_d;
      cyc_q <= cyc_d;
      long_q <= long_d;
      drv_q <= drv_d;
      done_q <= done_d;
      field_on_o <= (st_d == rsc_pkg::ST_ON);
    end
  end

  // ----------------------------------------
  // Outputs
  // ----------------------------------------
  // Open-drain style: enable and level follow the drive flop
  assign sync_o = drv_q;
  assign sync_oe_o = drv_q;
  assign stat_o.operational = (st_q == rsc_pkg::ST_ON) || (st_q == rsc_pkg::ST_OFF);
  assign stat_o.cycle = cyc_q;
  assign stat_o.last_cls = last_q;

  // ----------------------------------------
  // Checks
  // ----------------------------------------
  // Own drive length in ticks, only for the checks
  logic [13:0] dlen_q;
  always_ff @(posedge sys_clk_i) begin
    if (reset_i) begin
      dlen_q <= 14'h0000;
    end else begin
      dlen_q <= !drv_q ? 14'h0000 : tick ? dlen_q + 14'h0001 : dlen_q;
    end
  end

  a_mrs_own_len: assert property (@(posedge sys_clk_i) disable iff (reset_i)
    $fell(drv_q) && $past(kind_q) == rsc_pkg::CLS_MRS && st_q != rsc_pkg::ST_WATCH |->
    $past(dlen_q) >= `RSC_MRS_MIN && $past(dlen_q) <= `RSC_MRS_MAX)
    else $error("own sync pulse width out of window");
  a_hdx_own_len: assert property (@(posedge sys_clk_i) disable iff (reset_i)
    $fell(drv_q) && $past(kind_q) == rsc_pkg::CLS_HDX |->
    $past(dlen_q) >= `RSC_HDX_MIN && $past(dlen_q) <= `RSC_HDX_MAX)
    else $error("hdx extension width out of window");
  a_fdx_not_sync: assert property (@(posedge sys_clk_i) disable iff (reset_i)
    $fell(drv_q) && $past(kind_q) == rsc_pkg::CLS_FDX |->
    $past(dlen_q) < `RSC_MRS_MIN || $past(dlen_q) > `RSC_MRS_MAX)
    else $error("fdx extension looks like sync pulse");
  a_fdx_start: assert property (@(posedge sys_clk_i) disable iff (reset_i)
    $rose(drv_q) && kind_q == rsc_pkg::CLS_FDX |-> st_q == rsc_pkg::ST_ON &&
    t_q <= `RSC_FDX_START && !last_cyc)
    else $error("fdx extension started late");
  a_on_limit: assert property (@(posedge sys_clk_i) disable iff (reset_i)
    st_q == rsc_pkg::ST_ON |-> t_q <= `RSC_FDX_MAX)
    else $error("field on beyond limit");
  a_mrs_idle: assert property (@(posedge sys_clk_i) disable iff (reset_i)
    $rose(drv_q) && kind_q == rsc_pkg::CLS_MRS |-> !$past(line))
    else $error("sync pulse driven over activity");
  a_hdx_window: assert property (@(posedge sys_clk_i) disable iff (reset_i)
    $rose(drv_q) && kind_q == rsc_pkg::CLS_HDX |-> st_q == rsc_pkg::ST_OFF &&
    t_q >= `RSC_HDX_WIN_LO && t_q <= `RSC_OFF_T)
    else $error("hdx extension outside 3..4 ms");
  a_idle_off: assert property (@(posedge sys_clk_i) disable iff (reset_i)
    $past(st_q) == rsc_pkg::ST_OFF && st_q == rsc_pkg::ST_ON && !$past(long_q) &&
    cyc_q != `RSC_FIRST_CYC |-> $past(t_q) == `RSC_OFF_T)
    else $error("idle off period wrong");
  a_mrs_resync: assert property (@(posedge sys_clk_i) disable iff (reset_i)
    fall && is_mrs && st_q != rsc_pkg::ST_WATCH |=> st_q == rsc_pkg::ST_ON &&
    cyc_q == `RSC_FIRST_CYC && t_q == 14'h0000)
    else $error("sync pulse did not restart cycle");
  a_last_fixed: assert property (@(posedge sys_clk_i) disable iff (reset_i)
    st_q == rsc_pkg::ST_ON && last_cyc |-> t_q <= `RSC_ON_T && !fdx_own)
    else $error("tenth cycle on period not fixed");
endmodule : rsc_sync_ctrl

/* File: tb/rsc_peer_model.sv */
`timescale 1ns/1ps
// ----------------------------------------
// Peer reader on the shared sync line
// ----------------------------------------
module rsc_peer_model (
  input wire logic sys_clk_i,
  input wire logic go_i,
  input wire logic [15:0] len_i,
  output logic drive_o
);
  logic [15:0] left_q = 16'h0000;
  // Hold the line for len_i clocks; released line falls to its pull-down
  always_ff @(posedge sys_clk_i) begin
    if (go_i) begin
      left_q <= len_i;
    end else if (left_q != 16'h0000) begin
      left_q <= left_q - 16'h0001;
    end
  end
  assign drive_o = (left_q != 16'h0000);
endmodule : rsc_peer_model

/* File: tb/test_rsc_sync_ctrl.sv */
`timescale 1ns/1ps
module test_rsc_sync_ctrl;
  localparam int TK = 4;
  logic sys_clk_i = 1'b0;
  logic reset_i = 1'b1;
  logic hdx_detect_i = 1'b0;
  logic fdx_detect_i = 1'b0;
  logic fdx_done_i = 1'b0;
  logic peer_go = 1'b0;
  logic [15:0] peer_len = 16'h0000;
  logic sync_o, sync_oe_o, field_on_o, peer_drv, oe_seen;
  rsc_pkg::rsc_stat_t stat_o;
  wire logic line = (sync_oe_o & sync_o) | peer_drv;
  int error_cnt = 0;
  int n_tests = 0;
  int cyc = 0;
  int n, m;
  // ----------------------------------------
  // Clock, timeout and parts
  // ----------------------------------------
  initial begin
    forever #2.5 sys_clk_i = ~sys_clk_i;
  end
  // Cut a hang short; the whole run needs well under this
  always @(posedge sys_clk_i) begin
    cyc++;
    if (sync_oe_o === 1'b1) oe_seen = 1'b1;
    if (cyc == 80000) begin
      error_cnt++;
      end_sim();
    end
  end
  rsc_sync_ctrl #(.TICK_CYC(TK), .INIT_TO(14'h0032)) i_dut (
    .sys_clk_i(sys_clk_i), .reset_i(reset_i), .sync_i(line), .sync_o(sync_o),
    .sync_oe_o(sync_oe_o), .hdx_detect_i(hdx_detect_i), .fdx_detect_i(fdx_detect_i),
    .fdx_done_i(fdx_done_i), .field_on_o(field_on_o), .stat_o(stat_o));
  rsc_peer_model i_peer (.sys_clk_i(sys_clk_i), .go_i(peer_go), .len_i(peer_len),
    .drive_o(peer_drv));
  // ----------------------------------------
  // Shared helpers
  // ----------------------------------------
  function automatic logic sig(input int k);
    if (k == 0) return field_on_o;
    return sync_oe_o;
  endfunction : sig
  // Bounded wait for a level, counting clocks
  task automatic wait_lvl(input int k, input logic v, output int c);
    c = 0;
    while (sig(k) !== v && c < 20000) begin
      @(posedge sys_clk_i);
      #1;
      c++;
    end
  endtask : wait_lvl
  task automatic chk_rng(input int got, input int lo, input int hi);
    n_tests++;
    if (got < lo || got > hi) begin
      error_cnt++;
      $display("wrong value at %0t: got %h expected %h..%h", $time, got, lo, hi);
    end
  endtask : chk_rng
  task automatic chk_val(input logic [7:0] got, input logic [7:0] exp);
    n_tests++;
    if (got !== exp) begin
      error_cnt++;
      $display("wrong value at %0t: got %h expected %h", $time, got, exp);
    end
  endtask : chk_val
  task automatic peer_send(input int ticks);
    peer_len = 16'(ticks * TK);
    peer_go = 1'b1;
    @(posedge sys_clk_i);
    #1;
    peer_go = 1'b0;
  endtask : peer_send
  task automatic do_reset();
    reset_i = 1'b1;
    repeat (2) @(posedge sys_clk_i);
    #1;
    reset_i = 1'b0;
  endtask : do_reset
  // ----------------------------------------
  // Scenarios
  // ----------------------------------------
  task automatic t_silent();
    do_reset();
    wait_lvl(1, 1'b1, n);
    chk_rng(n, 49 * TK, 52 * TK + 6);
    wait_lvl(1, 1'b0, n);
    chk_rng(n, 199 * TK, 201 * TK);
    wait_lvl(0, 1'b1, n);
    chk_rng(n, 0, TK + 5);
    chk_val({7'h00, stat_o.operational}, 8'h01);
    chk_val({4'h0, stat_o.cycle}, 8'h01);
  endtask : t_silent
  task automatic t_idle();
    wait_lvl(0, 1'b0, n);
    chk_rng(n, 499 * TK, 501 * TK);
    wait_lvl(0, 1'b1, n);
    chk_rng(n, 39 * TK, 41 * TK + 4);
    chk_val({4'h0, stat_o.cycle}, 8'h02);
  endtask : t_idle
  task automatic t_tenth();
    while (stat_o.cycle !== 4'hA && cyc < 70000) begin
      wait_lvl(0, 1'b0, n);
      wait_lvl(0, 1'b1, n);
    end
    wait_lvl(0, 1'b0, n);
    chk_rng(n, 499 * TK, 501 * TK);
    wait_lvl(1, 1'b1, n);
    chk_rng(n, 0, 3);
    chk_val({7'h00, sync_o}, 8'h01);
    wait_lvl(1, 1'b0, n);
    chk_rng(n, 199 * TK, 201 * TK);
    wait_lvl(0, 1'b1, n);
    chk_val({4'h0, stat_o.cycle}, 8'h01);
  endtask : t_tenth
  task automatic t_hdx();
    hdx_detect_i = 1'b1;
    wait_lvl(0, 1'b0, n);
    wait_lvl(1, 1'b1, n);
    chk_rng(n, 34 * TK, 36 * TK + 4);
    wait_lvl(1, 1'b0, m);
    chk_rng(m, 163 * TK, 165 * TK);
    hdx_detect_i = 1'b0;
    n = n + m;
    wait_lvl(0, 1'b1, m);
    chk_rng(n + m, 199 * TK, 201 * TK + 6);
  endtask : t_hdx
  // Peer raises an extension; this reader must follow it
  task automatic t_peer_hdx();
    wait_lvl(0, 1'b0, n);
    repeat (32 * TK) @(posedge sys_clk_i);
    #1;
    peer_send(164);
    wait_lvl(0, 1'b1, n);
    chk_rng(n, 167 * TK, 169 * TK + 6);
    chk_val({5'h00, stat_o.last_cls}, {5'h00, rsc_pkg::CLS_HDX});
  endtask : t_peer_hdx
  task automatic t_fdx(input logic done);
    fdx_detect_i = 1'b1;
    wait_lvl(1, 1'b1, n);
    chk_rng(n, 489 * TK, 491 * TK + 4);
    if (done) begin
      fdx_done_i = 1'b1;
      @(posedge sys_clk_i);
      #1;
      fdx_done_i = 1'b0;
      n = n + 1;
    end
    fdx_detect_i = 1'b0;
    wait_lvl(0, 1'b0, m);
    if (done) chk_rng(n + m, 519 * TK, 521 * TK + 4);
    else chk_rng(n + m, 999 * TK, 1001 * TK);
    chk_val({7'h00, sync_oe_o}, 8'h00);
    wait_lvl(0, 1'b1, n);
  endtask : t_fdx
  // Peer sync pulse during power-up; this reader must not drive
  task automatic t_peer_mrs();
    do_reset();
    oe_seen = 1'b0;
    peer_send(200);
    wait_lvl(0, 1'b1, n);
    chk_rng(n, 200 * TK, 200 * TK + TK + 6);
    chk_val({7'h00, oe_seen}, 8'h00);
    chk_val({4'h0, stat_o.cycle}, 8'h01);
    chk_val({5'h00, stat_o.last_cls}, {5'h00, rsc_pkg::CLS_MRS});
  endtask : t_peer_mrs
  // ----------------------------------------
  // Sequence and verdict
  // ----------------------------------------
  task automatic end_sim();
    if (error_cnt == 0 && n_tests > 0) begin
      $display("Run complete: PASS");
    end else begin
      $display("Run complete: FAIL");
    end
    $finish;
  endtask : end_sim
  initial begin
    oe_seen = 1'b0;
    #1;
    t_silent();
    t_idle();
    t_tenth();
    t_hdx();
    t_peer_hdx();
    t_fdx(1'b0);
    t_fdx(1'b1);
    t_peer_mrs();
    end_sim();
  end
endmodule : test_rsc_sync_ctrl
